// [sfp_top.sv]
// forwarding policy: mirroring, VLAN look-up and per-port rate limits
//
// Notes on behaviour
// - frames received on an rx mirror port also go to the sniffer.
// - an option copies errored frames from rx mirror ports to sniffer.
// - frames destined to a tx mirror port also go to the sniffer.
// - in AND mode copy only if from rx source and to tx source.
// - in AND mode rx source frame to non-tx port gets no copy.
// - any set of mirror ports and any sniffer port, per port.
// - sixteen-entry VLAN table maps 12-bit VID to 4-bit filter id.
// - untagged or null-VID frames use the ingress port default VID.
// - invalid VID in VLAN mode drops the frame without learning.
// - filter id with DA picks ports, with SA drives learning.
// - DA missing from both tables floods to VLAN members.
// - static miss, dynamic hit sends to the dynamic entry port.
// - static hit with flag clear uses static ports ignoring filter id.
// - flag set: match uses static, else dynamic port or members.
// - unknown SA is learned, known SA has its age refreshed.
// - per-port ingress filtering and discard of non-default VID.
// - independent rx and tx byte limits per port in 32 kbit/s steps.
// - byte counters clear every one-second interval and then count.
// - rx count over the limit stops reception until interval end.
// - flow control within 8K (2K below 128 kbit/s) of the limit.
// - tx count over the limit stops sending until interval end.
// - with priority, separate high and low class limits per port.
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_top #(
  parameter int unsigned SEC_CYCLES = `SFP_SEC_CYCLES
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output wire logic [31:0] wb_dat_o,
  output wire logic        wb_ack_o,
  // frame look-up request
  input  wire logic        lk_req_i,
  input  wire logic [2:0]  lk_port_i,
  input  wire logic        lk_tagged_i,
  input  wire logic [11:0] lk_vid_i,
  input  wire logic        lk_err_i,
  output wire logic        lk_ready_o,
  // address table query and answer
  output wire logic        tbl_req_o,
  output wire logic [3:0]  filter_identifier_o,
  input  wire logic        tbl_rsp_i,
  input  wire logic        st_hit_i,
  input  wire logic [4:0]  st_ports_i,
  input  wire logic        use_filter_id_flag_i,
  input  wire logic [3:0]  st_filter_identifier_i,
  input  wire logic        dyn_hit_i,
  input  wire logic [2:0]  dyn_port_i,
  input  wire logic        sa_hit_i,
  // forwarding result
  output wire logic        res_valid_o,
  output wire logic        res_drop_o,
  output wire logic [4:0]  res_ports_o,
  output wire logic        learn_o,
  output wire logic        refresh_o,
  // byte events from the port MACs
  input  wire logic [4:0]  rx_byte_i,
  input  wire logic [4:0]  rx_hi_i,
  input  wire logic [4:0]  tx_byte_i,
  input  wire logic [4:0]  tx_hi_i,
  // rate limit state to the port MACs
  output wire logic [4:0]  rx_stop_lo_o,
  output wire logic [4:0]  rx_stop_hi_o,
  output wire logic [4:0]  tx_stop_lo_o,
  output wire logic [4:0]  tx_stop_hi_o,
  output wire logic [4:0]  rx_fc_o
);
  import sfp_pkg::*;

  localparam logic [24:0] TICK_LAST = 25'(SEC_CYCLES - 1);

  sfp_state_t s_r;
  sfp_state_t s_nxt;

  // port number to one-hot mask, ports above four give no mask
  function automatic logic [4:0] port_mask(input logic [2:0] p);
    port_mask = (p < 3'h5) ? 5'(5'h01 << p) : 5'h00;
  endfunction

  // first valid entry whose VID matches
  function automatic sfp_vlan_t vlan_find(input sfp_vlan_t [15:0] tbl,
                                          input logic [11:0]      vid);
    sfp_vlan_t r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (tbl[i].valid && tbl[i].vid == vid && !r.valid) begin
        r = tbl[i];
      end
    end
    return r;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = sel[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
    return old;
  endfunction

  // per-port rate counters: index k is {direction, class}
  wire [4:0] ov_rx_lo;
  wire [4:0] ov_rx_hi;
  wire [4:0] ov_tx_lo;
  wire [4:0] ov_tx_hi;
  wire [4:0] nr_rx_lo;
  wire [4:0] nr_rx_hi;

  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_port
      wire       prio;
      wire       rx_hi_sel;
      wire       tx_hi_sel;
      wire [3:0] ov;
      wire [3:0] nr;
      wire [3:0] byte_k;
      wire [3:0] fc_k;
      wire [11:0] lim_k [4];
      assign prio      = s_r.pcfg[p].prio_en;
      assign rx_hi_sel = prio & rx_hi_i[p];
      assign tx_hi_sel = prio & tx_hi_i[p];
      // without priority every byte lands in the low class counter
      assign byte_k = {tx_byte_i[p] & tx_hi_sel, tx_byte_i[p] & ~tx_hi_sel,
                       rx_byte_i[p] & rx_hi_sel, rx_byte_i[p] & ~rx_hi_sel};
      assign lim_k[0] = s_r.rxrate[p].lo;
      assign lim_k[1] = s_r.rxrate[p].hi;
      assign lim_k[2] = s_r.txrate[p].lo;
      assign lim_k[3] = s_r.txrate[p].hi;
      // flow control is a receive-side option only
      assign fc_k = {2'b00, {2{s_r.pcfg[p].fc_en}}};
      for (genvar k = 0; k < 4; k++) begin : g_cnt
        sfp_rate_cnt u_cnt (
          .clk_i   (clk_i),
          .rst_i   (rst_i),
          .tick_i  (s_r.tick),
          .byte_i  (byte_k[k]),
          .limit_i (lim_k[k]),
          .fc_en_i (fc_k[k]),
          .over_o  (ov[k]),
          .near_o  (nr[k])
        );
      end
      assign ov_rx_lo[p] = ov[0];
      assign ov_rx_hi[p] = ov[1];
      assign ov_tx_lo[p] = ov[2];
      assign ov_tx_hi[p] = ov[3];
      assign nr_rx_lo[p] = nr[0];
      assign nr_rx_hi[p] = nr[1];
      // with priority off the high class follows the low class
      assign rx_stop_lo_o[p] = ov[0];
      assign rx_stop_hi_o[p] = prio ? ov[1] : ov[0];
      assign tx_stop_lo_o[p] = ov[2];
      assign tx_stop_hi_o[p] = prio ? ov[3] : ov[2];
      assign rx_fc_o[p]      = nr[0] | (prio & nr[1]);
    end
  endgenerate

  // next state: interval tick, bus, look-up sequence
  always_comb begin
    logic        acc;
    logic [31:0] rd;
    logic [2:0]  pi;
    logic [1:0]  ri;
    logic        preg;
    sfp_pcfg_t   pc;
    logic [4:0]  pm;
    logic [11:0] vid_eff;
    sfp_vlan_t   ve;
    logic        drop;
    logic        filt_ok;
    logic [4:0]  dest;
    logic [4:0]  rxm;
    logic [4:0]  txm;
    logic [4:0]  snf;
    logic        rx_src;
    logic        tx_src;
    logic        copy;
    acc     = wb_cyc_i & wb_stb_i;
    rd      = 32'h00000000;
    pi      = wb_adr_i[6:4];
    ri      = wb_adr_i[3:2];
    preg    = (wb_adr_i[9:7] == 3'h2) && (pi < 3'h5);
    pc      = '0;
    pm      = 5'h00;
    vid_eff = 12'h000;
    ve      = '0;
    drop    = 1'b0;
    filt_ok = 1'b0;
    dest    = 5'h00;
    rx_src  = 1'b0;
    tx_src  = 1'b0;
    copy    = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rxm[i] = s_r.pcfg[i].rx_mirror;
      txm[i] = s_r.pcfg[i].tx_mirror;
      snf[i] = s_r.pcfg[i].sniffer;
    end
    s_nxt           = s_r;
    s_nxt.res_valid = 1'b0;
    s_nxt.learn     = 1'b0;
    s_nxt.refresh   = 1'b0;

    // one-second interval tick
    s_nxt.tick = s_r.tick_cnt == TICK_LAST;
    s_nxt.tick_cnt = s_nxt.tick ? 25'h0000000 : s_r.tick_cnt + 25'h0000001;

    // read data sampled with the request, ack one cycle later
    if (wb_adr_i == `SFP_OFS_CTRL) begin
      rd[`SFP_CTRL_MIRROR_AND] = s_r.mirror_and;
      rd[`SFP_CTRL_VLAN_MODE]  = s_r.vlan_mode;
      rd[`SFP_CTRL_ERR_MIRROR] = s_r.err_mirror;
    end else if (wb_adr_i == `SFP_OFS_STATUS) begin
      rd[`SFP_STAT_RX_STOP +: 5] = ov_rx_lo | ov_rx_hi;
      rd[`SFP_STAT_TX_STOP +: 5] = ov_tx_lo | ov_tx_hi;
      rd[`SFP_STAT_RX_FC +: 5]   = rx_fc_o;
    end else if (wb_adr_i[9:6] == 4'h1) begin
      rd = 32'(s_r.vlan[wb_adr_i[5:2]]);
    end else if (preg && ri == `SFP_OFS_PORT_CFG) begin
      rd[6:0] = s_r.pcfg[pi][6:0];
      rd[`SFP_PCFG_PVID_LSB +: 12] = s_r.pcfg[pi].pvid;
    end else if (preg && ri == `SFP_OFS_PORT_RXRATE) begin
      rd[`SFP_RATE_HI_LSB +: 12] = s_r.rxrate[pi].hi;
      rd[`SFP_RATE_LO_LSB +: 12] = s_r.rxrate[pi].lo;
    end else if (preg && ri == `SFP_OFS_PORT_TXRATE) begin
      rd[`SFP_RATE_HI_LSB +: 12] = s_r.txrate[pi].hi;
      rd[`SFP_RATE_LO_LSB +: 12] = s_r.txrate[pi].lo;
    end
    s_nxt.ack = acc & ~s_r.ack;
    if (acc && !s_r.ack) begin
      s_nxt.dat = rd;
    end

    // writes land on the edge where the master sees ack
    if (acc && s_r.ack && wb_we_i) begin
      rd = merge(rd, wb_dat_i, wb_sel_i);
      if (wb_adr_i == `SFP_OFS_CTRL) begin
        s_nxt.mirror_and = rd[`SFP_CTRL_MIRROR_AND];
        s_nxt.vlan_mode  = rd[`SFP_CTRL_VLAN_MODE];
        s_nxt.err_mirror = rd[`SFP_CTRL_ERR_MIRROR];
      end else if (wb_adr_i[9:6] == 4'h1) begin
        s_nxt.vlan[wb_adr_i[5:2]] = rd[21:0];
      end else if (preg && ri == `SFP_OFS_PORT_CFG) begin
        s_nxt.pcfg[pi] = {rd[`SFP_PCFG_PVID_LSB +: 12], rd[6:0]};
      end else if (preg && ri == `SFP_OFS_PORT_RXRATE) begin
        s_nxt.rxrate[pi].hi = rd[`SFP_RATE_HI_LSB +: 12];
        s_nxt.rxrate[pi].lo = rd[`SFP_RATE_LO_LSB +: 12];
      end else if (preg && ri == `SFP_OFS_PORT_TXRATE) begin
        s_nxt.txrate[pi].hi = rd[`SFP_RATE_HI_LSB +: 12];
        s_nxt.txrate[pi].lo = rd[`SFP_RATE_LO_LSB +: 12];
      end
    end

    // look-up: VLAN stage, then address table stage
    case (s_r.lk)
      SFP_LK_IDLE: begin
        if (lk_req_i) begin
          pm = port_mask(lk_port_i);
          if (lk_port_i < 3'h5) begin
            pc = s_r.pcfg[lk_port_i];
          end
          vid_eff = (!lk_tagged_i || lk_vid_i == 12'h000) ?
                    pc.pvid : lk_vid_i;
          ve = vlan_find(s_r.vlan, vid_eff);
          if (s_r.vlan_mode) begin
            drop = !ve.valid;
            drop = drop | (pc.ing_filt && (ve.members & pm) == 5'h00) |
                   (pc.disc_npvid && vid_eff != pc.pvid);
            s_nxt.filter_identifier = ve.filter_identifier;
            s_nxt.members           = ve.members;
          end else begin
            s_nxt.filter_identifier = 4'h0;
            s_nxt.members           = 5'h1F;
          end
          if (drop) begin
            // dropped here: no result ports, no learning
            s_nxt.res_valid = 1'b1;
            s_nxt.res_drop  = 1'b1;
            s_nxt.res_ports = 5'h00;
          end else begin
            s_nxt.lk   = SFP_LK_TABLE;
            s_nxt.port = lk_port_i;
            s_nxt.err  = lk_err_i;
          end
        end
      end
      SFP_LK_TABLE: begin
        if (tbl_rsp_i) begin
          // outside VLAN mode the filter id flag has no meaning
          filt_ok = !s_r.vlan_mode || !use_filter_id_flag_i ||
                    st_filter_identifier_i == s_r.filter_identifier;
          if (st_hit_i && filt_ok) begin
            dest = st_ports_i;
          end else if (dyn_hit_i) begin
            dest = port_mask(dyn_port_i);
          end else begin
            dest = s_r.members;
          end
          rx_src = |(rxm & port_mask(s_r.port));
          tx_src = |(txm & dest);
          copy   = s_r.mirror_and ? (rx_src & tx_src) :
                                    (rx_src | tx_src);
          if (s_r.err) begin
            // a bad frame only reaches the sniffer, and only by option
            dest = 5'h00;
            copy = copy & rx_src & s_r.err_mirror;
          end
          s_nxt.res_ports = dest | (copy ? snf : 5'h00);
          s_nxt.res_drop  = (dest | (copy ? snf : 5'h00)) == 5'h00;
          s_nxt.res_valid = 1'b1;
          s_nxt.learn     = !s_r.err && !sa_hit_i;
          s_nxt.refresh   = !s_r.err && sa_hit_i;
          s_nxt.lk        = SFP_LK_IDLE;
        end
      end
      default: begin
        s_nxt.lk = SFP_LK_IDLE;
      end
    endcase
  end

  // state register with reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r            <= '0;
      s_r.lk         <= SFP_LK_IDLE;
      s_r.mirror_and <= 1'(`SFP_CTRL_RST >> `SFP_CTRL_MIRROR_AND);
      s_r.vlan_mode  <= 1'(`SFP_CTRL_RST >> `SFP_CTRL_VLAN_MODE);
      s_r.err_mirror <= 1'(`SFP_CTRL_RST >> `SFP_CTRL_ERR_MIRROR);
      for (int i = 0; i < 5; i++) begin
        s_r.pcfg[i].pvid <= `SFP_PVID_RST;
        s_r.rxrate[i]    <= {`SFP_RATE_RST, `SFP_RATE_RST};
        s_r.txrate[i]    <= {`SFP_RATE_RST, `SFP_RATE_RST};
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign wb_dat_o            = s_r.dat;
  assign wb_ack_o            = s_r.ack;
  assign lk_ready_o          = s_r.lk == SFP_LK_IDLE;
  assign tbl_req_o           = s_r.lk == SFP_LK_TABLE;
  assign filter_identifier_o = s_r.filter_identifier;
  assign res_valid_o         = s_r.res_valid;
  assign res_drop_o          = s_r.res_drop;
  assign res_ports_o         = s_r.res_ports;
  assign learn_o             = s_r.learn;
  assign refresh_o           = s_r.refresh;

endmodule

// [sfp_cfg.svh]
// offsets, field positions, reset values and timing of the forwarding policy
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// register offsets (byte addresses, in-port ones as word indexes)
`define SFP_OFS_CTRL        10'h000
`define SFP_OFS_STATUS      10'h004
`define SFP_OFS_VLAN_BASE   10'h040
`define SFP_OFS_PORT_BASE   10'h100
`define SFP_PORT_STRIDE     10'h010
`define SFP_OFS_PORT_CFG    2'h0
`define SFP_OFS_PORT_RXRATE 2'h1
`define SFP_OFS_PORT_TXRATE 2'h2

// control register fields
`define SFP_CTRL_MIRROR_AND 0
`define SFP_CTRL_VLAN_MODE  1
`define SFP_CTRL_ERR_MIRROR 2

// per-port config fields
`define SFP_PCFG_RX_MIRROR  0
`define SFP_PCFG_TX_MIRROR  1
`define SFP_PCFG_SNIFFER    2
`define SFP_PCFG_ING_FILT   3
`define SFP_PCFG_DISC_NPVID 4
`define SFP_PCFG_FC_EN      5
`define SFP_PCFG_PRIO_EN    6
`define SFP_PCFG_PVID_LSB   16

// rate register fields: high class low, low class high
`define SFP_RATE_HI_LSB     0
`define SFP_RATE_LO_LSB     16

// status register fields
`define SFP_STAT_RX_STOP    0
`define SFP_STAT_TX_STOP    8
`define SFP_STAT_RX_FC      16

// reset values
`define SFP_CTRL_RST        3'h0
`define SFP_PVID_RST        12'h001
`define SFP_RATE_RST        12'h000

// timing: interval and the rate step
`define SFP_CLK_HZ          20000000
`define SFP_INTERVAL_MS     1000
`define SFP_SEC_CYCLES      (`SFP_CLK_HZ / 1000 * `SFP_INTERVAL_MS)
`define SFP_STEP_KBPS       32
`define SFP_STEP_BYTES      (`SFP_STEP_KBPS * 1000 / 8)
`define SFP_FC_KNEE_KBPS    128
`define SFP_FC_KNEE_STEPS   (`SFP_FC_KNEE_KBPS / `SFP_STEP_KBPS)
`define SFP_FC_MARGIN_HI    8192
`define SFP_FC_MARGIN_LO    2048

`endif

// [sfp_pkg.sv]
// types shared by the forwarding policy modules
package sfp_pkg;

  typedef enum logic {SFP_LK_IDLE, SFP_LK_TABLE} sfp_lk_state_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  members;
    logic [3:0]  filter_identifier;
    logic [11:0] vid;
  } sfp_vlan_t;

  typedef struct packed {
    logic [11:0] pvid;
    logic        prio_en;
    logic        fc_en;
    logic        disc_npvid;
    logic        ing_filt;
    logic        sniffer;
    logic        tx_mirror;
    logic        rx_mirror;
  } sfp_pcfg_t;

  typedef struct packed {
    logic [11:0] lo;
    logic [11:0] hi;
  } sfp_rate_t;

  typedef struct packed {
    logic [24:0] count;
    logic        over;
    logic        near;
  } sfp_rcnt_t;

  typedef struct packed {
    logic                 mirror_and;
    logic                 vlan_mode;
    logic                 err_mirror;
    sfp_vlan_t [15:0]     vlan;
    sfp_pcfg_t [4:0]      pcfg;
    sfp_rate_t [4:0]      rxrate;
    sfp_rate_t [4:0]      txrate;
    logic                 ack;
    logic [31:0]          dat;
    logic [24:0]          tick_cnt;
    logic                 tick;
    sfp_lk_state_t        lk;
    logic [2:0]           port;
    logic                 err;
    logic [3:0]           filter_identifier;
    logic [4:0]           members;
    logic                 res_valid;
    logic                 res_drop;
    logic [4:0]           res_ports;
    logic                 learn;
    logic                 refresh;
  } sfp_state_t;

endpackage

// [sfp_rate_cnt.sv]
// one-second byte counter with limit and flow-control threshold
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_rate_cnt (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // interval and traffic
  input  wire logic        tick_i,
  input  wire logic        byte_i,
  // settings
  input  wire logic [11:0] limit_i,
  input  wire logic        fc_en_i,
  // state
  output wire logic        over_o,
  output wire logic        near_o
);
  import sfp_pkg::*;

  sfp_rcnt_t   s_r;
  sfp_rcnt_t   s_nxt;
  logic [24:0] limit_bytes;
  logic [24:0] margin;

  // limit in bytes per interval, one step is 32 kbit/s
  assign limit_bytes = 25'(limit_i) * 25'(`SFP_STEP_BYTES);
  // small limits get the narrow margin so they can open at all
  assign margin = (limit_i >= 12'(`SFP_FC_KNEE_STEPS)) ?
                  25'(`SFP_FC_MARGIN_HI) : 25'(`SFP_FC_MARGIN_LO);

  // count, clear on interval start, saturate rather than wrap
  always_comb begin
    s_nxt = s_r;
    if (tick_i) begin
      s_nxt.count = byte_i ? 25'h0000001 : 25'h0000000;
    end else if (byte_i && s_r.count != 25'h1FFFFFF) begin
      s_nxt.count = s_r.count + 25'h0000001;
    end
    s_nxt.over = s_nxt.count > limit_bytes;
    s_nxt.near = fc_en_i &&
                 ({1'b0, s_nxt.count} + {1'b0, margin} >=
                  {1'b0, limit_bytes});
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign over_o = s_r.over;
  assign near_o = s_r.near;

endmodule

// [sfp_top_assertions.sv]
// concurrent checks on the forwarding policy ports
`timescale 1ns/1ps
module sfp_top_assertions (
  // system
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus and look-up
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       lk_req_i,
  input wire logic       lk_ready_o,
  input wire logic       tbl_req_o,
  input wire logic       tbl_rsp_i,
  input wire logic       res_valid_o,
  input wire logic       learn_o,
  input wire logic       refresh_o,
  // rate
  input wire logic [4:0] rx_byte_i,
  input wire logic [4:0] rx_stop_lo_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a look-up taken, and the table answer closing it
  sequence s_taken;
    lk_req_i && lk_ready_o;
  endsequence
  sequence s_answer;
    tbl_req_o && tbl_rsp_i;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acked one cycle later");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_take_moves: assert property (s_taken |=> res_valid_o || tbl_req_o)
    else $error("taken look-up neither dropped nor queried");
  a_answer_done: assert property (s_answer |=> res_valid_o && !tbl_req_o)
    else $error("table answer gave no result");
  // a result with no table query is a vlan drop: nothing learned
  a_drop_nolearn: assert property (res_valid_o && !$past(tbl_req_o)
    |-> !learn_o && !refresh_o)
    else $error("dropped frame learned");
  a_one_update: assert property (res_valid_o |-> !(learn_o && refresh_o))
    else $error("learn and refresh together");
  a_pulse_tied: assert property (learn_o || refresh_o |-> res_valid_o)
    else $error("learn or refresh without a result");
  a_stop_cause: assert property ($rose(rx_stop_lo_o[0])
    |-> $past(rx_byte_i[0]) || $past(rx_byte_i[0], 2))
    else $error("rx stop rose with no byte");
endmodule

bind sfp_top sfp_top_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .lk_req_i, .lk_ready_o, .tbl_req_o, .tbl_rsp_i,
  .res_valid_o, .learn_o, .refresh_o, .rx_byte_i, .rx_stop_lo_o);

// [sfp_tbl_model.sv]
// address table stand-in answering each query after a set wait
`timescale 1ns/1ps
module sfp_tbl_model (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // query and answer
  input  wire logic        req_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic [15:0] ans_i,
  output logic             rsp_o,
  output logic [15:0]      ans_o
);
  logic [3:0] wait_r;
  // one answer per query; a slow table just counts longer
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || rsp_o) begin
      wait_r <= 4'h0;
      rsp_o  <= 1'b0;
    end else if (wait_r == lat_i) begin
      rsp_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
  // fields are junk outside the answer cycle, never the last value
  assign ans_o = rsp_o ? ans_i : ~ans_i;
endmodule

// [sfp_top_tb.sv]
// self-checking bench for the forwarding policy block
`timescale 1ns/1ps
module sfp_top_tb;
  logic        clk_i, rst_i, cyc, stb, we, lk_req, tg, er, rsp, ack;
  logic        tq, rv, rdp, lrn, rfr, rdy;
  logic [9:0]  adr;
  logic [31:0] wd, rd, q;
  logic [2:0]  lp;
  logic [11:0] vid;
  logic [4:0]  rxb, txb, res_ports, rxs, txs, fc;
  logic [4:0]  hi, rxsh, txsh;
  logic [15:0] ans, ans_m;
  logic [3:0]  lat, flt, fq;
  int          fails, checks, k;
  logic [15:0] ta [6] = '{16'h0408, 16'h0418, 16'h84F8, 16'h86E8,
                          16'h86F8, 16'h8678};
  logic [4:0]  te [6] = '{5'h06, 5'h10, 5'h01, 5'h06, 5'h10, 5'h01};

  sfp_top #(.SEC_CYCLES(10000)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .lk_req_i(lk_req),
    .lk_port_i(lp), .lk_tagged_i(tg), .lk_vid_i(vid), .lk_err_i(er),
    .lk_ready_o(rdy), .tbl_req_o(tq), .filter_identifier_o(flt),
    .tbl_rsp_i(rsp), .st_hit_i(ans_m[15]), .st_ports_i(ans_m[14:10]),
    .use_filter_id_flag_i(ans_m[9]), .st_filter_identifier_i(ans_m[8:5]),
    .dyn_hit_i(ans_m[4]), .dyn_port_i(ans_m[3:1]), .sa_hit_i(ans_m[0]),
    .res_valid_o(rv), .res_drop_o(rdp), .res_ports_o(res_ports),
    .learn_o(lrn), .refresh_o(rfr), .rx_byte_i(rxb), .rx_hi_i(hi),
    .tx_byte_i(txb), .tx_hi_i(hi), .rx_stop_lo_o(rxs),
    .rx_stop_hi_o(rxsh), .tx_stop_lo_o(txs), .tx_stop_hi_o(txsh),
    .rx_fc_o(fc));
  sfp_tbl_model u_tbl (.clk_i, .rst_i, .req_i(tq), .lat_i(lat),
    .ans_i(ans), .rsp_o(rsp), .ans_o(ans_m));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, g, input string n);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  // classic single cycle; held until ack is seen on a rising edge
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, q, "read");
  endtask

  // one look-up, then the result against the expected mask
  task automatic lkx(input logic [2:0] p, input logic t,
    input logic [11:0] v, input logic e, input logic [15:0] a,
    input logic [4:0] ep);
    int n = 0;
    @(posedge clk_i);
    ans <= a;
    lp <= p;
    tg <= t;
    vid <= v;
    er <= e;
    lk_req <= 1'b1;
    @(posedge clk_i);
    lk_req <= 1'b0;
    #1;
    while (rv !== 1'b1 && n < 30) begin
      if (tq === 1'b1) fq = flt;
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 30) fails++;
    if (ep == 5'h00) chk(1, rdp, "drop");
    else chk(ep, res_ports, "ports");
  endtask

  // byte pulses on the ports in m, n edges long
  task automatic byt(input logic [9:0] m, input int n);
    @(posedge clk_i);
    {txb, rxb} <= m;
    repeat (n) @(posedge clk_i);
    {txb, rxb} <= 10'h000;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // a hang ends the run as a mismatch
  initial begin
    #2000000;
    fails++;
    close_out();
  end

  initial begin
    {fails, checks, cyc, stb, we, adr, wd, lk_req, lp, tg, vid} = 0;
    {er, rxb, txb, hi, ans, lat} = 0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place
    rdc(10'h000, 32'h0);
    rdc(10'h100, 32'h0001_0000);
    rdc(10'h104, 32'h0);
    rdc(10'h3FC, 32'h0);
    // mirroring: port0 rx source, port1 tx source, port4 sniffer
    bus(1'b1, 10'h100, 32'h0001_0001);
    bus(1'b1, 10'h110, 32'h0001_0002);
    bus(1'b1, 10'h140, 32'h0001_0004);
    lkx(0, 0, 0, 0, 16'h0016, 5'h18);
    lat = 4'h3;
    lkx(2, 0, 0, 0, 16'h0012, 5'h12);
    lkx(0, 0, 0, 0, 16'h0012, 5'h12);
    bus(1'b1, 10'h000, 32'h4);
    lkx(0, 0, 0, 1, 16'h0016, 5'h10);
    bus(1'b1, 10'h000, 32'h1);
    lkx(0, 0, 0, 1, 16'h0016, 5'h00);
    lkx(0, 0, 0, 0, 16'h0016, 5'h08);
    lkx(0, 0, 0, 0, 16'h0012, 5'h12);
    lkx(2, 0, 0, 0, 16'h0012, 5'h02);
    // vlan mode: vid 5 -> filter id 3, members ports 1 and 2
    lat = 4'h0;
    bus(1'b1, 10'h040, 32'h0026_3005);
    bus(1'b1, 10'h000, 32'h2);
    bus(1'b1, 10'h100, 32'h0001_0000);
    bus(1'b1, 10'h110, 32'h0005_0000);
    for (k = 0; k < 6; k++)
      lkx(2, 1, 12'h005, 0, ta[k], te[k]);
    chk(4'h3, fq, "filter id");
    chk(1, lrn, "learn");
    lkx(2, 1, 12'h005, 0, 16'h0409, 5'h06);
    chk(1, rfr, "refresh");
    lkx(1, 0, 12'h000, 0, 16'h0408, 5'h06);
    lkx(1, 1, 12'h000, 0, 16'h0408, 5'h06);
    lkx(2, 1, 12'h007, 0, 16'h0408, 5'h00);
    chk(0, lrn, "learn");
    bus(1'b1, 10'h100, 32'h0005_0008);
    lkx(0, 1, 12'h005, 0, 16'h0408, 5'h00);
    bus(1'b1, 10'h120, 32'h0001_0010);
    lkx(2, 1, 12'h005, 0, 16'h0408, 5'h00);
    // rates at reset are zero: one byte stops rx and tx
    bus(1'b1, 10'h100, 32'h0001_0020);
    byt(10'h021, 1);
    chk(1, rxs[0], "rx stop");
    chk(1, txs[0], "tx stop");
    for (k = 0; k < 10100 && rxs[0] !== 1'b0; k++)
      @(posedge clk_i);
    #1;
    chk(1, k > 9000 && k < 10010, "interval");
    chk(0, txs[0], "tx stop");
    // one step is 4000 bytes; flow control 2048 below it
    bus(1'b1, 10'h104, 32'h0001_0000);
    byt(10'h001, 1951);
    chk(0, fc[0], "fc");
    byt(10'h001, 1);
    chk(1, fc[0], "fc");
    byt(10'h001, 2048);
    chk(0, rxs[0], "rx stop");
    byt(10'h001, 1);
    chk(1, rxs[0], "rx stop");
    chk(1, rxsh[0], "rx stop hi");
    rdc(10'h004, 32'h0001_0001);
    // port 3 with priority: high class bytes meet only the high limits
    bus(1'b1, 10'h130, 32'h0001_0040);
    bus(1'b1, 10'h134, 32'h0001_0000);
    hi <= 5'h08;
    byt(10'h108, 1);
    chk(0, rxs[3], "rx stop lo");
    chk(1, rxsh[3], "rx stop hi");
    chk(0, txs[3], "tx stop lo");
    chk(1, txsh[3], "tx stop hi");
    close_out();
  end
endmodule
